// ---- include/async_serial_pkg.sv ----
package async_serial_pkg;

    // ************************************************************
    // i/o space offsets
    // ************************************************************
    localparam logic [7:0] CTRL_B0_OFS     = 8'h02;
    localparam logic [7:0] CTRL_B1_OFS     = 8'h03;
    localparam logic [7:0] EXT_CTRL0_OFS   = 8'h12;
    localparam logic [7:0] TIME_CONST_L0_OFS = 8'h1A;
    localparam logic [7:0] TIME_CONST_H0_OFS = 8'h1B;

    // ************************************************************
    // control register b fields
    // ************************************************************
    localparam int CTS_PRESCALE_POS = 5;
    localparam int PARITY_ODD_POS   = 4;
    localparam int DIVIDE_RATIO_POS = 3;
    localparam int SRC_SEL_MSB      = 2;
    localparam int SRC_SEL_LSB      = 0;
    localparam logic [7:0] CTRL_B_RESET = 8'h07;
    localparam logic [2:0] SRC_EXTERNAL = 3'h7;

    // ************************************************************
    // extension control fields
    // ************************************************************
    localparam int EXT_X1_CLK_POS     = 4;
    localparam int EXT_COUNTER16_POS  = 3;
    localparam int EXT_SEND_BREAK_POS = 0;
    localparam logic [7:0] EXT_CTRL_RESET   = 8'h00;
    localparam logic [7:0] TIME_CONST_RESET = 8'h00;

    // ************************************************************
    // divider figures
    // ************************************************************
    localparam logic [4:0] PRESCALE_LO = 5'h0A;
    localparam logic [4:0] PRESCALE_HI = 5'h1E;
    localparam logic [5:0] RATIO_LO    = 6'h10 - 6'h01;
    localparam logic [5:0] RATIO_HI    = 6'h3F;

endpackage

// ---- hw/baud_divider.sv ----
`timescale 1ns/1ps

module baud_divider
(
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        clk_en_i,
    // settings
    input  wire logic        prescale_sel_i,
    input  wire logic        divide_ratio_i,
    input  wire logic [2:0]  source_sel_i,
    input  wire logic        counter16_i,
    input  wire logic [15:0] time_const_i,
    input  wire logic        x1_clk_i,
    // external clock edge, already synchronised
    input  wire logic        ext_edge_i,
    // ticks
    output logic             sample_tick_o,
    output logic             bit_tick_o
);

    logic [4:0]  pre_cnt_reg;
    logic [5:0]  spd_cnt_reg;
    logic [15:0] tc_cnt_reg;
    logic [5:0]  ratio_cnt_reg;
    logic [4:0]  pre_lim;
    logic [5:0]  spd_lim;
    logic [5:0]  ratio_lim;
    logic        pre_tick;
    logic        spd_tick;
    logic        tc_tick;
    logic        ext_sel;

    assign ext_sel   = (source_sel_i == async_serial_pkg::SRC_EXTERNAL);
    assign pre_lim   = (prescale_sel_i ? async_serial_pkg::PRESCALE_HI
                                       : async_serial_pkg::PRESCALE_LO)
                       - 5'h01;
    assign pre_tick  = (pre_cnt_reg == pre_lim);
    assign spd_lim   = 6'((7'h01 << source_sel_i) - 7'h01);
    assign spd_tick  = pre_tick && (spd_cnt_reg == spd_lim);
    assign tc_tick   = (tc_cnt_reg == time_const_i);
    assign ratio_lim = divide_ratio_i ? async_serial_pkg::RATIO_HI
                                      : async_serial_pkg::RATIO_LO;

    // external source bypasses prescaler and speed stage
    always_comb
    begin
        if (ext_sel)
            sample_tick_o = ext_edge_i;
        else if (counter16_i)
            sample_tick_o = tc_tick;
        else
            sample_tick_o = spd_tick;
    end

    assign bit_tick_o = (ext_sel && x1_clk_i) ? ext_edge_i
                      : (sample_tick_o && ratio_cnt_reg == ratio_lim);

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pre_cnt_reg <= 5'h00;
        else if (clk_en_i)
            pre_cnt_reg <= pre_tick ? 5'h00 : pre_cnt_reg + 5'h01;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            spd_cnt_reg <= 6'h00;
        else if (clk_en_i && pre_tick)
            spd_cnt_reg <= spd_tick ? 6'h00 : spd_cnt_reg + 6'h01;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tc_cnt_reg <= 16'h0000;
        else if (clk_en_i)
            tc_cnt_reg <= tc_tick ? 16'h0000 : tc_cnt_reg + 16'h0001;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ratio_cnt_reg <= 6'h00;
        else if (clk_en_i && sample_tick_o)
            ratio_cnt_reg <= (ratio_cnt_reg == ratio_lim) ? 6'h00
                           : ratio_cnt_reg + 6'h01;
    end

endmodule

// ---- hw/async_serial_baud_control.sv ----
`timescale 1ns/1ps

// How it works
// - reading the cts/prescale bit returns the clear-to-send pin level.
// - a high clear-to-send pin holds the transmit-empty flag at zero; on channel 1 only with its cts pin select set.
// - channel 1 readback is valid only with its cts pin select set.
// - reset does not change the clear-to-send readback value.
// - written prescale bit picks system clock divide by 10 or 30.
// - reset clears the written prescale select to zero.
// - parity sense picks even at 0, odd at 1; reset clears it.
// - parity sense never decides whether parity is used.
// - divide ratio bit picks sampling divide by 16 or 64.
// - reset clears the divide ratio bit.
// - source select codes 0 to 6 divide by 1..64; 7 external.
// - reset sets source select to the external clock code.
// - during reset the shared pins are clock inputs.
// - dma channel 0 memory/io mode makes channel 0 pin a dma request.
// - channel 1 clock pin disable makes that pin the dma end output.
// - bit clock follows system clock, prescale, ratio and source select.
// - channel 0 extension register at 12H, all bits reset to zero.
// - counter mode bit enables a 16-bit baud counter.
// - send break forces the transmit data pin low.
module async_serial_baud_control
(
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       clk_en_i,
    // internal i/o space
    input  wire logic [7:0] io_addr_i,
    input  wire logic       io_wr_i,
    input  wire logic       io_rd_i,
    input  wire logic [7:0] io_wdata_i,
    output logic      [7:0] io_rdata_o,
    // modem pins, active low
    input  wire logic       cts0_n_i,
    input  wire logic       cts1_n_i,
    // shared clock pins
    input  wire logic       chan0_clock_pin_i,
    input  wire logic       chan1_clock_pin_i,
    output logic            chan1_clock_pin_o,
    output logic            chan1_clock_pin_oe_o,
    // dma controller side
    input  wire logic       dma0_mem_io_i,
    input  wire logic       dma_end0_n_i,
    output logic            dma_request0_n_o,
    // other control bits
    input  wire logic       chan1_cts_pin_select_i,
    input  wire logic       chan1_clock_pin_disable_i,
    input  wire logic [1:0] parity_enable_bit_i,
    // transmit shifter side
    input  wire logic [1:0] tx_buf_empty_i,
    input  wire logic       tx_serial_i,
    output logic      [1:0] tx_empty_flag_o,
    output logic            tx_data_pin_o,
    // line options: parity per channel, extension register for channel 0 only
    output logic      [1:0] parity_odd_select_o,
    output logic      [1:0] parity_check_o,
    output logic      [7:0] ext_ctrl0_o,
    // ticks per channel
    output logic      [1:0] sample_tick_o,
    output logic      [1:0] bit_tick_o
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    // no reset here: the readback must not be disturbed by reset
    logic [1:0] cts_meta_reg;
    logic [1:0] cts_sync_reg;
    logic [1:0] ck_meta_reg;
    logic [1:0] ck_sync_reg;
    logic [1:0] ck_last_reg;

    always_ff @(posedge clk_sys_i)
    begin
        if (clk_en_i)
        begin
            cts_meta_reg <= {cts1_n_i, cts0_n_i};
            cts_sync_reg <= cts_meta_reg;
        end
    end

    // third stage only feeds the rising edge detector
    always_ff @(posedge clk_sys_i)
    begin
        if (clk_en_i)
        begin
            ck_meta_reg <= {chan1_clock_pin_i, chan0_clock_pin_i};
            ck_sync_reg <= ck_meta_reg;
            ck_last_reg <= ck_sync_reg;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0]  ctrl_b_reg [2];
    logic [7:0]  ext_ctrl0_reg;
    logic [15:0] time_const0_reg;
    logic [1:0]  cts_high;
    logic [1:0]  ext_edge;
    logic [1:0]  pin_is_clock;

    // channel 1 pin level only counts when the pin carries cts
    assign cts_high[0] = cts_sync_reg[0];
    assign cts_high[1] = cts_sync_reg[1] && chan1_cts_pin_select_i;

    // a shared pin feeds the divider only while it is a clock input
    assign pin_is_clock[0] = !dma0_mem_io_i;
    assign pin_is_clock[1] = !chan1_clock_pin_disable_i;
    assign ext_edge = ck_sync_reg & ~ck_last_reg & pin_is_clock;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_b_reg[0] <= async_serial_pkg::CTRL_B_RESET;
            ctrl_b_reg[1] <= async_serial_pkg::CTRL_B_RESET;
        end
        else if (clk_en_i && io_wr_i)
        begin
            if (io_addr_i == async_serial_pkg::CTRL_B0_OFS)
                ctrl_b_reg[0] <= io_wdata_i;
            if (io_addr_i == async_serial_pkg::CTRL_B1_OFS)
                ctrl_b_reg[1] <= io_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ext_ctrl0_reg <= async_serial_pkg::EXT_CTRL_RESET;
        else if (clk_en_i && io_wr_i
                 && io_addr_i == async_serial_pkg::EXT_CTRL0_OFS)
            ext_ctrl0_reg <= io_wdata_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            time_const0_reg <= {2{async_serial_pkg::TIME_CONST_RESET}};
        else if (clk_en_i && io_wr_i)
        begin
            if (io_addr_i == async_serial_pkg::TIME_CONST_L0_OFS)
                time_const0_reg[7:0] <= io_wdata_i;
            if (io_addr_i == async_serial_pkg::TIME_CONST_H0_OFS)
                time_const0_reg[15:8] <= io_wdata_i;
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    logic [7:0] rd_mux;

    always_comb
    begin
        rd_mux = 8'h00;
        case (io_addr_i)
            async_serial_pkg::CTRL_B0_OFS:
            begin
                rd_mux = ctrl_b_reg[0];
                rd_mux[async_serial_pkg::CTS_PRESCALE_POS] = cts_high[0];
            end
            async_serial_pkg::CTRL_B1_OFS:
            begin
                rd_mux = ctrl_b_reg[1];
                rd_mux[async_serial_pkg::CTS_PRESCALE_POS] = cts_high[1];
            end
            async_serial_pkg::EXT_CTRL0_OFS:
                rd_mux = ext_ctrl0_reg;
            async_serial_pkg::TIME_CONST_L0_OFS:
                rd_mux = time_const0_reg[7:0];
            async_serial_pkg::TIME_CONST_H0_OFS:
                rd_mux = time_const0_reg[15:8];
            default:
                rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            io_rdata_o <= 8'h00;
        else if (clk_en_i && io_rd_i)
            io_rdata_o <= rd_mux;
    end

    // ************************************************************
    // baud generators
    // ************************************************************
    logic [1:0] samp_raw;
    logic [1:0] bit_raw;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            // only channel 0 has the extension and time constant bits
            baud_divider u_div
            (
                .clk_sys_i      (clk_sys_i),
                .rst_n_i        (rst_n_i),
                .clk_en_i       (clk_en_i),
                .prescale_sel_i (ctrl_b_reg[ch]
                                 [async_serial_pkg::CTS_PRESCALE_POS]),
                .divide_ratio_i (ctrl_b_reg[ch]
                                 [async_serial_pkg::DIVIDE_RATIO_POS]),
                .source_sel_i   (ctrl_b_reg[ch]
                                 [async_serial_pkg::SRC_SEL_MSB:
                                  async_serial_pkg::SRC_SEL_LSB]),
                .counter16_i    ((ch == 0) && ext_ctrl0_reg
                                 [async_serial_pkg::EXT_COUNTER16_POS]),
                .time_const_i   (time_const0_reg),
                .x1_clk_i       ((ch == 0) && ext_ctrl0_reg
                                 [async_serial_pkg::EXT_X1_CLK_POS]),
                .ext_edge_i     (ext_edge[ch]),
                .sample_tick_o  (samp_raw[ch]),
                .bit_tick_o     (bit_raw[ch])
            );

            always_ff @(posedge clk_sys_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    tx_empty_flag_o[ch] <= 1'b0;
                else if (clk_en_i)
                    tx_empty_flag_o[ch] <= tx_buf_empty_i[ch]
                                           && !cts_high[ch];
            end

            // enable follows control a only, never the sense bit
            always_ff @(posedge clk_sys_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    parity_odd_select_o[ch] <= 1'b0;
                    parity_check_o[ch]      <= 1'b0;
                end
                else if (clk_en_i)
                begin
                    parity_odd_select_o[ch] <= ctrl_b_reg[ch]
                        [async_serial_pkg::PARITY_ODD_POS];
                    parity_check_o[ch] <= parity_enable_bit_i[ch];
                end
            end

            always_ff @(posedge clk_sys_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    sample_tick_o[ch] <= 1'b0;
                    bit_tick_o[ch]    <= 1'b0;
                end
                else if (clk_en_i)
                begin
                    sample_tick_o[ch] <= samp_raw[ch];
                    bit_tick_o[ch]    <= bit_raw[ch];
                end
            end
        end
    endgenerate

    // ************************************************************
    // pins
    // ************************************************************
    // channel 1 pin stays an input unless dma end owns it
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            chan1_clock_pin_oe_o <= 1'b0;
            chan1_clock_pin_o    <= 1'b1;
        end
        else if (clk_en_i)
        begin
            chan1_clock_pin_oe_o <= chan1_clock_pin_disable_i;
            chan1_clock_pin_o    <= dma_end0_n_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            dma_request0_n_o <= 1'b1;
        else if (clk_en_i)
            dma_request0_n_o <= dma0_mem_io_i ? ck_sync_reg[0]
                                              : 1'b1;
    end

    // break overrides whatever the shifter is sending
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tx_data_pin_o <= 1'b1;
        else if (clk_en_i)
            tx_data_pin_o <= tx_serial_i && !ext_ctrl0_reg
                             [async_serial_pkg::EXT_SEND_BREAK_POS];
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ext_ctrl0_o <= async_serial_pkg::EXT_CTRL_RESET;
        else if (clk_en_i)
            ext_ctrl0_o <= ext_ctrl0_reg;
    end

endmodule

// ---- sim/async_serial_baud_control_properties.sv ----
`timescale 1ns/1ps
module baud_control_checker
(
    // clock and reset
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    input wire logic       clk_en_i,
    // register access
    input wire logic [7:0] io_addr_i,
    input wire logic       io_rd_i,
    input wire logic [7:0] io_rdata_o,
    // pins
    input wire logic       cts0_n_i,
    input wire logic       cts1_n_i,
    input wire logic       chan0_clock_pin_i,
    input wire logic       chan1_clock_pin_o,
    input wire logic       chan1_clock_pin_oe_o,
    input wire logic       dma0_mem_io_i,
    input wire logic       dma_end0_n_i,
    input wire logic       dma_request0_n_o,
    input wire logic       chan1_cts_pin_select_i,
    input wire logic       chan1_clock_pin_disable_i,
    // transmit side
    input wire logic       tx_serial_i,
    input wire logic [1:0] tx_empty_flag_o,
    input wire logic       tx_data_pin_o,
    input wire logic [7:0] ext_ctrl0_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    // ************************************************************
    // sequences
    // ************************************************************
    // four quiet edges let the two-flop synchroniser settle
    sequence cts0_settled;
        ($stable(cts0_n_i) && clk_en_i)[*4];
    endsequence
    sequence cts1_settled;
        ($stable(cts1_n_i) && $stable(chan1_cts_pin_select_i)
            && clk_en_i)[*4];
    endsequence
    sequence rd_at(logic [7:0] a);
        io_rd_i && clk_en_i && io_addr_i == a;
    endsequence

    // ************************************************************
    // properties
    // ************************************************************
    a_cts0_readback:
        assert property (cts0_settled ##0 rd_at(8'h02)
            |=> io_rdata_o[5] == $past(cts0_n_i))
        else $error("cts0 readback wrong");
    a_cts1_readback:
        assert property (cts1_settled ##0 rd_at(8'h03)
            |=> io_rdata_o[5] == ($past(cts1_n_i)
                && $past(chan1_cts_pin_select_i)))
        else $error("cts1 readback wrong");
    a_cts_holds_empty:
        assert property (cts0_settled ##0 cts0_n_i |-> !tx_empty_flag_o[0])
        else $error("empty flag set while cts high");
    a_dma_req_idle:
        assert property (!dma0_mem_io_i && clk_en_i |=> dma_request0_n_o)
        else $error("dma request outside dma mode");
    a_dma_req_follows:
        assert property ((dma0_mem_io_i && $stable(chan0_clock_pin_i)
            && clk_en_i)[*4] |-> dma_request0_n_o == chan0_clock_pin_i)
        else $error("dma request not following pin");
    a_end_drives_pin:
        assert property (chan1_clock_pin_disable_i && clk_en_i
            |=> chan1_clock_pin_oe_o
                && chan1_clock_pin_o == $past(dma_end0_n_i))
        else $error("dma end not on channel 1 pin");
    a_pin_input_only:
        assert property (!chan1_clock_pin_disable_i && clk_en_i
            |=> !chan1_clock_pin_oe_o)
        else $error("channel 1 pin driven as clock");
    a_break_low:
        assert property ((ext_ctrl0_o[0] && clk_en_i) ##1 ext_ctrl0_o[0]
            |-> !tx_data_pin_o)
        else $error("break not driving line low");
    a_break_clear:
        assert property ((!ext_ctrl0_o[0] && clk_en_i) ##1 !ext_ctrl0_o[0]
            |-> tx_data_pin_o == $past(tx_serial_i))
        else $error("transmit data not passed");
endmodule

bind async_serial_baud_control baud_control_checker u_checker
(
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .io_addr_i(io_addr_i), .io_rd_i(io_rd_i), .io_rdata_o(io_rdata_o),
    .cts0_n_i(cts0_n_i), .cts1_n_i(cts1_n_i),
    .chan0_clock_pin_i(chan0_clock_pin_i),
    .chan1_clock_pin_o(chan1_clock_pin_o),
    .chan1_clock_pin_oe_o(chan1_clock_pin_oe_o),
    .dma0_mem_io_i(dma0_mem_io_i), .dma_end0_n_i(dma_end0_n_i),
    .dma_request0_n_o(dma_request0_n_o),
    .chan1_cts_pin_select_i(chan1_cts_pin_select_i),
    .chan1_clock_pin_disable_i(chan1_clock_pin_disable_i),
    .tx_serial_i(tx_serial_i), .tx_empty_flag_o(tx_empty_flag_o),
    .tx_data_pin_o(tx_data_pin_o), .ext_ctrl0_o(ext_ctrl0_o)
);

// ---- sim/line_partner.sv ----
`timescale 1ns/1ps
module line_partner
(
    // clock
    input  wire logic       clk_sys_i,
    // commands
    input  wire logic [1:0] cts_high_i,
    input  wire logic [1:0] run_i,
    input  wire logic [7:0] half_i,
    // line side
    output logic      [1:0] cts_n_o,
    output logic      [1:0] clock_pin_o
);
    logic [7:0] cnt_reg = 8'h00;
    logic       phase_reg = 1'b0;

    assign cts_n_o = cts_high_i;
    // data clock stands low between bursts, it is not free running
    assign clock_pin_o = run_i & {2{phase_reg}};

    always @(posedge clk_sys_i)
    begin
        if (run_i == 2'h0 || cnt_reg == half_i - 8'h01)
            cnt_reg <= 8'h00;
        else
            cnt_reg <= cnt_reg + 8'h01;
        if (run_i == 2'h0)
            phase_reg <= 1'b0;
        else if (cnt_reg == half_i - 8'h01)
            phase_reg <= ~phase_reg;
    end
endmodule

// ---- sim/async_serial_baud_control_bench.sv ----
`timescale 1ns/1ps
module async_serial_baud_control_bench;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       en = 1'b1;
    logic [7:0] addr = 8'h00;
    logic       wr_s = 1'b0;
    logic       rd_s = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic       dma_mode = 1'b0;
    logic       end_n = 1'b1;
    logic       sel = 1'b0;
    logic       dis = 1'b0;
    logic [1:0] par_en = 2'h0;
    logic [1:0] buf_empty = 2'h3;
    logic       tx_ser = 1'b1;
    logic [1:0] cts_high = 2'h0;
    logic [1:0] run = 2'h0;
    logic [7:0] half = 8'h0A;
    logic [7:0] rdata;
    logic       ch1_o;
    logic       ch1_oe;
    logic       req_n;
    logic       txpin;
    logic [1:0] flag;
    logic [1:0] par_odd;
    logic [1:0] par_chk;
    logic [7:0] ext;
    logic [1:0] stick;
    logic [1:0] btick;
    logic [1:0] cts_n;
    logic [1:0] pin;
    wire  logic ch1_pin;
    wire  logic [3:0] ticks;
    int         fails = 0;
    int         n_tests = 0;

    // the wire carries whichever party drives it
    assign ch1_pin = ch1_oe ? ch1_o : pin[1];
    assign ticks = {btick, stick};

    async_serial_baud_control dut
    (
        .clk_sys_i(clk), .rst_n_i(rst_n), .clk_en_i(en),
        .io_addr_i(addr), .io_wr_i(wr_s), .io_rd_i(rd_s),
        .io_wdata_i(wdata), .io_rdata_o(rdata),
        .cts0_n_i(cts_n[0]), .cts1_n_i(cts_n[1]),
        .chan0_clock_pin_i(pin[0]), .chan1_clock_pin_i(ch1_pin),
        .chan1_clock_pin_o(ch1_o), .chan1_clock_pin_oe_o(ch1_oe),
        .dma0_mem_io_i(dma_mode), .dma_end0_n_i(end_n),
        .dma_request0_n_o(req_n), .chan1_cts_pin_select_i(sel),
        .chan1_clock_pin_disable_i(dis), .parity_enable_bit_i(par_en),
        .tx_buf_empty_i(buf_empty), .tx_serial_i(tx_ser),
        .tx_empty_flag_o(flag), .tx_data_pin_o(txpin),
        .parity_odd_select_o(par_odd), .parity_check_o(par_chk),
        .ext_ctrl0_o(ext), .sample_tick_o(stick), .bit_tick_o(btick)
    );

    line_partner u_partner
    (
        .clk_sys_i(clk), .cts_high_i(cts_high), .run_i(run),
        .half_i(half), .cts_n_o(cts_n), .clock_pin_o(pin)
    );

    initial
    begin
        forever #4 clk = ~clk;
    end

    task automatic final_report();
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic io_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic io_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        check($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rdata});
    endtask

    // measures tick spacing between the second and third ticks, skipping the first gap after a change
    task automatic period(input int s, input int exp);
        int n;
        int k;
        n = 0;
        k = 0;
        while (k < 3 && n < 50000)
        begin
            @(posedge clk);
            #1;
            n++;
            if (ticks[s] === 1'b1)
            begin
                k++;
                n = (k < 3) ? 0 : n;
            end
        end
        if (k < 3)
        begin
            fails++;
            final_report();
        end
        check($sformatf("tick %0d period", s), exp, n);
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        check("oe in reset", 16'h0, ch1_oe);
        check("ext in reset", 16'h0, ext);
        rst_n <= 1'b1;
        io_read(8'h02, 8'h07);
        io_read(8'h12, 8'h00);
        io_read(8'h1B, 8'h00);
        io_read(8'h40, 8'h00);
        cts_high <= 2'h3;
        idle(5);
        check("empty flags", 16'h2, flag);
        io_read(8'h02, 8'h27);
        io_read(8'h03, 8'h07);
        sel <= 1'b1;
        io_read(8'h03, 8'h27);
        check("empty flags", 16'h0, flag);
        cts_high <= 2'h0;
        idle(5);
        check("empty flags", 16'h3, flag);
        for (int s = 0; s < 7; s++)
        begin
            io_write(8'h02, s[7:0]);
            period(0, 10 << s);
        end
        io_write(8'h02, 8'h20);
        period(0, 30);
        period(2, 480);
        io_write(8'h02, 8'h08);
        period(2, 640);
        io_write(8'h03, 8'h00);
        period(1, 10);
        period(3, 160);
        io_write(8'h02, 8'h10);
        idle(2);
        check("parity sense", 16'h1, par_odd[0]);
        par_en <= 2'h2;
        idle(2);
        check("parity use", 16'h2, par_chk);
        check("parity sense", 16'h1, par_odd[0]);
        io_write(8'h02, 8'h07);
        run <= 2'h1;
        period(0, 20);
        period(2, 320);
        io_write(8'h12, 8'h10);
        period(2, 20);
        dma_mode <= 1'b1;
        run <= 2'h0;
        idle(6);
        check("dma request", 16'h0, req_n);
        dma_mode <= 1'b0;
        idle(2);
        check("dma request", 16'h1, req_n);
        dis <= 1'b1;
        end_n <= 1'b0;
        idle(2);
        check("pin enable", 16'h1, ch1_oe);
        check("pin level", 16'h0, ch1_o);
        dis <= 1'b0;
        idle(2);
        check("pin enable", 16'h0, ch1_oe);
        io_write(8'h12, 8'h01);
        idle(3);
        check("tx pin", 16'h0, txpin);
        io_write(8'h12, 8'h00);
        idle(3);
        check("tx pin", 16'h1, txpin);
        io_write(8'h1A, 8'h04);
        io_write(8'h1B, 8'h00);
        io_write(8'h02, 8'h00);
        io_write(8'h12, 8'h08);
        io_read(8'h12, 8'h08);
        io_read(8'h1A, 8'h04);
        period(0, 5);
        en <= 1'b0;
        io_write(8'h12, 8'h01);
        idle(3);
        check("frozen tx pin", 16'h1, txpin);
        en <= 1'b1;
        io_read(8'h12, 8'h08);
        final_report();
    end
endmodule
